// File: logic/drive_shutdown_sequencer.sv
// Shutdown sequencer from the drive state down to inverter and own power-off.
//
// Notes on behaviour
// - In drive state, ignition or wake off moves the sequencer to state 6.
// - In drive state, a detected charge plug also moves to state 6.
// - State 6 sends a zero torque request to the inverter.
// - State 6 opens the main contactor once speed is below the stop level.
// - State 11 commands the inverter to disable its PWM.
// - State 11 waits a settable delay before moving to discharge request.
// - State 12 issues the discharge command when the feature is enabled.
// - A settable timeout leaves state 12 without discharge success feedback.
// - State 13 checks that bus discharge is done before moving on.
// - Discharge done is set when bus voltage is below the table level.
// - State 14 removes inverter power, then own power unless held.
// - Power keep holds when charger or converter asks; state stays 14.
// - Discharge disabled skips discharge and raises a skipped status flag.
// - Indicator LED colour changes at every shutdown state change.
// - State 5 is drive/reverse, 3 park/neutral, 4 the start-safe gate.
`timescale 1ns/10ps
module drive_shutdown_sequencer
	import shutdown_pkg::*;
#(
	parameter int PWM_OFF_CYC = PWM_OFF_WAIT_CYC,
	parameter int DIS_LIMIT_CYC = DISCHARGE_LIMIT_CYC
) (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_CE,
	input wire logic I_IGNITION,
	input wire logic I_WAKE,
	input wire logic I_PLUG_DETECT,
	input wire logic I_PARK_REQ,
	input wire logic I_DRIVE_REQ,
	input wire logic I_START_SAFE_OK,
	input wire logic [SPEED_W-1:0] I_MOTOR_SPEED,
	input wire logic [SPEED_W-1:0] I_STOP_SPEED,
	input wire logic [VOLT_W-1:0] I_BUS_VOLTAGE,
	input wire logic I_DISCHARGE_FEATURE_SELECT,
	input wire logic I_DISCHARGE_ACK,
	input wire logic I_CHARGER_HOLD,
	input wire logic I_DCDC_HOLD,
	input wire logic I_TBL_WR,
	input wire logic [TBL_AW-1:0] I_TBL_WADDR,
	input wire logic [VOLT_W-1:0] I_TBL_WDATA,
	input wire logic [TBL_AW-1:0] I_TBL_SEL,
	output logic [STATE_W-1:0] O_OPERATING_STATE,
	output logic O_ZERO_TORQUE,
	output logic O_CONTACTOR_OPEN,
	output logic O_PWM_DISABLE,
	output logic O_DISCHARGE_CMD,
	output logic O_DISCHARGE_DONE,
	output logic O_DISCHARGE_SKIPPED,
	output logic O_INVERTER_POWER_OFF,
	output logic O_SELF_POWER_OFF,
	output logic O_POWER_KEEP_STATUS,
	output logic [LED_W-1:0] O_LED_COLOUR
);
	// The seven control inputs (ignition, wake, plug, park, drive, ack, hold) pass two flip-flops; the first stage feeds only the second.
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] raw;
	logic ign;
	logic wake;
	logic plug;
	logic park_req;
	logic drive_req;
	logic dis_ack;
	logic hold_req;

	assign raw = {I_IGNITION, I_WAKE, I_PLUG_DETECT, I_PARK_REQ,
		I_DRIVE_REQ, I_DISCHARGE_ACK, I_CHARGER_HOLD | I_DCDC_HOLD};
	assign {ign, wake, plug, park_req, drive_req, dis_ack, hold_req} = sync2;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (I_CE) begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	logic [VOLT_W-1:0] done_level;

	level_table #(
		.DEPTH(TBL_DEPTH),
		.AW(TBL_AW),
		.DW(VOLT_W)
	) u_level_table (
		.i_clk(I_CLK),
		.i_nrst(I_NRST),
		.i_ce(I_CE),
		.i_wr(I_TBL_WR),
		.i_waddr(I_TBL_WADDR),
		.i_wdata(I_TBL_WDATA),
		.i_raddr(I_TBL_SEL),
		.o_rdata(done_level)
	);

	operating_state_t state;
	operating_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic contactor_open;
	logic next_contactor_open;
	logic [LED_W-1:0] led;
	logic [LED_W-1:0] next_led;
	logic dis_done;
	logic dis_en;

	assign dis_done = I_BUS_VOLTAGE < done_level;
	assign dis_en = I_DISCHARGE_FEATURE_SELECT;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_contactor_open = contactor_open;
		unique case (state)
			ST_PARK: begin
				if (drive_req) begin
					next_state = ST_SAFE;
				end
			end
			ST_SAFE: begin
				if (!drive_req) begin
					next_state = ST_PARK;
				end else if (I_START_SAFE_OK && ign && wake && !plug) begin
					next_state = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (!ign || !wake) begin
					next_state = ST_ZERO_TQ;
				end else if (plug) begin
					next_state = ST_ZERO_TQ;
				end else if (park_req) begin
					next_state = ST_PARK;
				end
			end
			ST_ZERO_TQ: begin
				if (I_MOTOR_SPEED < I_STOP_SPEED) begin
					next_contactor_open = 1'b1;
					next_state = ST_PWM_OFF;
					next_cnt = '0;
				end
			end
			ST_PWM_OFF: begin
				next_cnt = cnt + 1'b1;
				if (cnt >= CNT_W'(PWM_OFF_CYC - 1)) begin
					next_state = ST_DIS_REQ;
					next_cnt = '0;
				end
			end
			ST_DIS_REQ: begin
				next_cnt = cnt + 1'b1;
				if (!dis_en || dis_ack) begin
					next_state = ST_DIS_CHK;
					next_cnt = '0;
				end else if (cnt >= CNT_W'(DIS_LIMIT_CYC - 1)) begin
					next_state = ST_DIS_CHK;
					next_cnt = '0;
				end
			end
			ST_DIS_CHK: begin
				if (!dis_en || dis_done) begin
					next_state = ST_POWER_OFF;
				end
			end
			ST_POWER_OFF: begin
				next_state = ST_POWER_OFF;
			end
			default: begin
				next_state = ST_PARK;
			end
		endcase
		// A state change in shutdown steps the indicator colour.
		next_led = led;
		if (next_state != state && next_state >= ST_ZERO_TQ) begin
			next_led = led + 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state <= ST_PARK;
			cnt <= '0;
			contactor_open <= 1'b0;
			led <= LED_OFF;
		end else if (I_CE) begin
			state <= next_state;
			cnt <= next_cnt;
			contactor_open <= next_contactor_open;
			led <= next_led;
		end
	end

	logic in_shutdown;
	logic past_pwm;
	logic next_inv_off;
	logic next_self_off;

	assign in_shutdown = state >= ST_ZERO_TQ;
	assign past_pwm = state >= ST_PWM_OFF;
	assign next_inv_off = state == ST_POWER_OFF;
	// Own supply drops only after inverter power is already off.
	assign next_self_off = O_INVERTER_POWER_OFF && !hold_req;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_OPERATING_STATE <= ST_PARK;
			O_ZERO_TORQUE <= 1'b0;
			O_CONTACTOR_OPEN <= 1'b0;
			O_PWM_DISABLE <= 1'b1;
			O_DISCHARGE_CMD <= 1'b0;
			O_DISCHARGE_DONE <= 1'b0;
			O_DISCHARGE_SKIPPED <= 1'b0;
			O_INVERTER_POWER_OFF <= 1'b0;
			O_SELF_POWER_OFF <= 1'b0;
			O_POWER_KEEP_STATUS <= 1'b0;
			O_LED_COLOUR <= LED_OFF;
		end else if (I_CE) begin
			O_OPERATING_STATE <= state;
			O_ZERO_TORQUE <= in_shutdown;
			O_CONTACTOR_OPEN <= contactor_open;
			O_PWM_DISABLE <= past_pwm || state != ST_DRIVE;
			O_DISCHARGE_CMD <= state == ST_DIS_REQ && dis_en;
			O_DISCHARGE_DONE <= dis_done;
			O_DISCHARGE_SKIPPED <= !dis_en;
			O_INVERTER_POWER_OFF <= next_inv_off;
			O_SELF_POWER_OFF <= next_self_off;
			O_POWER_KEEP_STATUS <= hold_req;
			O_LED_COLOUR <= led;
		end
	end
endmodule

// File: logic/shutdown_pkg.sv
// State codes, widths and timing constants of the shutdown sequencer.
package shutdown_pkg;
	localparam int STATE_W = 4;
	localparam int SPEED_W = 16;
	localparam int VOLT_W = 16;
	localparam int LED_W = 3;
	localparam int CLK_MHZ = 250;
	localparam int PWM_OFF_WAIT_US = 10;
	localparam int PWM_OFF_WAIT_CYC = PWM_OFF_WAIT_US * CLK_MHZ;
	localparam int DISCHARGE_LIMIT_MS = 2000;
	localparam int DISCHARGE_LIMIT_CYC = DISCHARGE_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	localparam int TBL_DEPTH = 4;
	localparam int TBL_AW = 2;
	localparam logic [LED_W-1:0] LED_OFF = 3'h0;
	typedef enum logic [STATE_W-1:0] {
		ST_PARK = 4'h3,
		ST_SAFE = 4'h4,
		ST_DRIVE = 4'h5,
		ST_ZERO_TQ = 4'h6,
		ST_PWM_OFF = 4'hb,
		ST_DIS_REQ = 4'hc,
		ST_DIS_CHK = 4'hd,
		ST_POWER_OFF = 4'he
	} operating_state_t;
endpackage

// File: logic/level_table.sv
// Small table of discharge-done voltage levels with registered read.
`timescale 1ns/10ps
module level_table #(
	parameter int DEPTH = 4,
	parameter int AW = 2,
	parameter int DW = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] next_rdata;

	always_comb begin
		next_rdata = mem[i_raddr];
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= '0;
		end else if (i_ce) begin
			o_rdata <= next_rdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && i_wr) begin
			mem[i_waddr] <= i_wdata;
		end
	end
endmodule

// File: tb/drive_shutdown_sequencer_monitor.sv
// Checker of the shutdown sequencer port behaviour.
`timescale 1ns/10ps
module drive_shutdown_sequencer_monitor
	import shutdown_pkg::*;
#(
	parameter int PWM_OFF_CYC = 20,
	parameter int DIS_LIMIT_CYC = 50
) (
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_IGNITION,
	input wire logic I_WAKE,
	input wire logic I_DISCHARGE_FEATURE_SELECT,
	input wire logic [STATE_W-1:0] O_OPERATING_STATE,
	input wire logic O_ZERO_TORQUE,
	input wire logic O_CONTACTOR_OPEN,
	input wire logic O_DISCHARGE_CMD,
	input wire logic [LED_W-1:0] O_LED_COLOUR
);
	logic [CNT_W-1:0] cnt;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_NRST);
	// Counts cycles since the visible state last changed.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cnt <= '0;
		end else begin
			cnt <= $changed(O_OPERATING_STATE) ? '0 : cnt + 1'b1;
		end
	end
	sequence s_off;
		O_OPERATING_STATE == ST_DRIVE && !(I_IGNITION && I_WAKE);
	endsequence
	property p_leave; s_off |-> ##[1:6] O_OPERATING_STATE == ST_ZERO_TQ;
	endproperty
	a_leave: assert property (p_leave) else $error("no entry");
	property p_zt; O_OPERATING_STATE == ST_ZERO_TQ |-> O_ZERO_TORQUE;
	endproperty
	a_zt: assert property (p_zt) else $error("no zero torque");
	property p_co; $rose(O_CONTACTOR_OPEN) |-> O_OPERATING_STATE ==
		ST_PWM_OFF && $past(O_OPERATING_STATE) == ST_ZERO_TQ;
	endproperty
	a_co: assert property (p_co) else $error("contactor early");
	property p_wait; $fell(O_OPERATING_STATE == ST_PWM_OFF) |->
		cnt >= PWM_OFF_CYC - 2 && cnt <= PWM_OFF_CYC + 1;
	endproperty
	a_wait: assert property (p_wait) else $error("pwm wait off");
	property p_cmd; O_OPERATING_STATE == ST_DIS_REQ &&
		I_DISCHARGE_FEATURE_SELECT |-> O_DISCHARGE_CMD;
	endproperty
	a_cmd: assert property (p_cmd) else $error("no discharge cmd");
	property p_lim; O_OPERATING_STATE == ST_DIS_REQ |->
		cnt <= DIS_LIMIT_CYC + 2;
	endproperty
	a_lim: assert property (p_lim) else $error("no timeout");
	property p_term; O_OPERATING_STATE == ST_POWER_OFF |=>
		O_OPERATING_STATE == ST_POWER_OFF;
	endproperty
	a_term: assert property (p_term) else $error("left end");
	property p_led; $changed(O_OPERATING_STATE) && O_OPERATING_STATE >=
		ST_ZERO_TQ |-> O_LED_COLOUR == 3'($past(O_LED_COLOUR) + 3'h1);
	endproperty
	a_led: assert property (p_led) else $error("led no step");
endmodule

// File: tb/inverter_model.sv
// Behavioural inverter answering discharge commands.
`timescale 1ns/10ps
module inverter_model
	import shutdown_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_cmd,
	input wire logic i_ack_en,
	output logic o_ack,
	output logic [VOLT_W-1:0] o_volt
);
	// The bus halves each cycle under discharge; success once it is low.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_volt <= 16'h0190;
			o_ack <= 1'b0;
		end else if (i_cmd && i_ack_en) begin
			o_volt <= o_volt >> 1;
			o_ack <= o_volt < 16'h0020;
		end
	end
endmodule

// File: tb/drive_shutdown_sequencer_tb_top.sv
// Directed testbench of the shutdown sequencer.
`timescale 1ns/10ps
module drive_shutdown_sequencer_tb_top
	import shutdown_pkg::*;
;
	localparam int PC = 20;
	localparam int DL = 50;
	logic clk = 1'b0, nrst = 1'b0, ign = 1'b0, wake = 1'b0, plug = 1'b0;
	logic drv = 1'b0, fsel = 1'b1, ack_en = 1'b1, hold = 1'b0, wr = 1'b0;
	logic park = 1'b0;
	logic ack, zt, co, pd, dc, dd, ds, ip, sp, pk;
	logic [15:0] speed = 16'h0100, lvl = 16'h0040, volt;
	logic [STATE_W-1:0] st;
	logic [LED_W-1:0] led;
	int n_fail = 0;
	int n_checks = 0;
	always #2 clk = ~clk;
	drive_shutdown_sequencer #(.PWM_OFF_CYC(PC), .DIS_LIMIT_CYC(DL))
		u_drive_shutdown_sequencer (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1),
		.I_IGNITION(ign), .I_WAKE(wake), .I_PLUG_DETECT(plug),
		.I_PARK_REQ(park), .I_DRIVE_REQ(drv), .I_START_SAFE_OK(drv),
		.I_MOTOR_SPEED(speed), .I_STOP_SPEED(lvl), .I_BUS_VOLTAGE(volt),
		.I_DISCHARGE_FEATURE_SELECT(fsel), .I_DISCHARGE_ACK(ack),
		.I_CHARGER_HOLD(hold), .I_DCDC_HOLD(hold), .I_TBL_WR(wr),
		.I_TBL_WADDR(2'h0), .I_TBL_WDATA(lvl), .I_TBL_SEL(2'h0),
		.O_OPERATING_STATE(st), .O_ZERO_TORQUE(zt), .O_CONTACTOR_OPEN(co),
		.O_PWM_DISABLE(pd), .O_DISCHARGE_CMD(dc), .O_DISCHARGE_DONE(dd),
		.O_DISCHARGE_SKIPPED(ds), .O_INVERTER_POWER_OFF(ip),
		.O_SELF_POWER_OFF(sp), .O_POWER_KEEP_STATUS(pk), .O_LED_COLOUR(led));
	inverter_model u_inverter_model (.i_clk(clk), .i_nrst(nrst), .i_cmd(dc),
		.i_ack_en(ack_en), .o_ack(ack), .o_volt(volt));
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic go(input logic [3:0] s, input int lim);
		for (int i = 0; i < lim && st !== s; i++) begin
			@(posedge clk);
			#1;
		end
		chk("state", 16'(s), 16'(st));
		if (st !== s) close_out();
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic up(input logic f, input logic a);
		@(posedge clk);
		nrst <= 1'b0;
		fsel <= f;
		hold <= ~f;
		ack_en <= a;
		speed <= 16'h0100;
		{ign, wake, plug, drv} <= 4'h0;
		pause(3);
		chk("reset state", 16'(ST_PARK), 16'(st));
		@(posedge clk);
		{nrst, wr, ign, wake, drv} <= 5'h1f;
		go(ST_DRIVE, 20);
		chk("pwm disable", 16'h0, 16'(pd));
		@(posedge clk);
	endtask
	initial begin
		up(1'b1, 1'b1);
		ign <= 1'b0;
		go(ST_ZERO_TQ, 10);
		chk("zero torque", 16'h1, 16'(zt));
		@(posedge clk);
		ign <= 1'b1;
		pause(12);
		chk("held state", 16'(ST_ZERO_TQ), 16'(st));
		chk("contactor", 16'h0, 16'(co));
		@(posedge clk);
		speed <= 16'h0000;
		go(ST_PWM_OFF, 6);
		chk("contactor", 16'h1, 16'(co));
		chk("pwm disable", 16'h1, 16'(pd));
		go(ST_DIS_REQ, PC + 6);
		chk("discharge cmd", 16'h1, 16'(dc));
		go(ST_DIS_CHK, 30);
		go(ST_POWER_OFF, 30);
		chk("done", 16'h1, 16'(dd));
		chk("skipped", 16'h0, 16'(ds));
		chk("inverter off", 16'h1, 16'(ip));
		pause(3);
		chk("self off", 16'h1, 16'(sp));
		chk("led", 16'h5, 16'(led));
		$display("test 1 done");
		up(1'b0, 1'b1);
		{park, drv} <= 2'h2;
		go(ST_PARK, 10);
		@(posedge clk);
		{park, drv} <= 2'h1;
		go(ST_DRIVE, 10);
		@(posedge clk);
		plug <= 1'b1;
		speed <= 16'h0000;
		go(ST_ZERO_TQ, 10);
		go(ST_POWER_OFF, PC + 20);
		pause(4);
		chk("skipped", 16'h1, 16'(ds));
		chk("keep", 16'h1, 16'(pk));
		chk("self off", 16'h0, 16'(sp));
		chk("held state", 16'(ST_POWER_OFF), 16'(st));
		$display("test 2 done");
		up(1'b1, 1'b0);
		wake <= 1'b0;
		speed <= 16'h0000;
		go(ST_DIS_REQ, PC + 20);
		pause(DL - 5);
		chk("waiting", 16'(ST_DIS_REQ), 16'(st));
		go(ST_DIS_CHK, 20);
		pause(10);
		chk("stuck check", 16'(ST_DIS_CHK), 16'(st));
		chk("done", 16'h0, 16'(dd));
		$display("test 3 done");
		close_out();
	end
endmodule
bind drive_shutdown_sequencer drive_shutdown_sequencer_monitor #(
	.PWM_OFF_CYC(PWM_OFF_CYC), .DIS_LIMIT_CYC(DIS_LIMIT_CYC))
	u_drive_shutdown_sequencer_monitor (.I_CLK(I_CLK), .I_NRST(I_NRST),
	.I_IGNITION(I_IGNITION), .I_WAKE(I_WAKE),
	.I_DISCHARGE_FEATURE_SELECT(I_DISCHARGE_FEATURE_SELECT),
	.O_OPERATING_STATE(O_OPERATING_STATE), .O_ZERO_TORQUE(O_ZERO_TORQUE),
	.O_CONTACTOR_OPEN(O_CONTACTOR_OPEN), .O_DISCHARGE_CMD(O_DISCHARGE_CMD),
	.O_LED_COLOUR(O_LED_COLOUR));
